// ===== include/rsp_pkg.sv
// package of constants and types for the reset source and power-up control block
package rsp_pkg;

    // ************************************************************
    // register map and field layout
    // ************************************************************
    localparam logic [3:0] ADDR_RESET_CAUSE  = 4'h0;
    localparam logic [3:0] ADDR_WDOG_CTRL    = 4'h1;
    localparam logic [3:0] ADDR_RECOV_CTRL   = 4'h2;
    localparam logic [3:0] ADDR_IRQ_STATUS   = 4'h3;
    localparam logic [3:0] ADDR_IRQ_ENABLE   = 4'h4;
    localparam logic [3:0] ADDR_IRQ_CLEAR    = 4'h5;
    localparam logic [3:0] ADDR_PWR_STATUS   = 4'h6;

    localparam int BIT_POR_FLAG  = 0;
    localparam int BIT_EXT_FLAG  = 1;
    localparam int BIT_BOD_FLAG  = 2;
    localparam int BIT_WDR_FLAG  = 3;
    localparam int BIT_DBG_FLAG  = 4;
    localparam int BIT_WDOG_IE   = 6;
    localparam int BIT_WDOG_FLAG = 7;
    localparam int BIT_RECOV_EN  = 0;

    localparam int IRQ_BIT_RESET = 0;
    localparam int IRQ_BIT_WDOG  = 1;
    localparam int IRQ_BIT_READY = 2;

    localparam logic [7:0] RESET_CAUSE_MASK = 8'h1F;
    localparam logic [7:0] WDOG_CTRL_RST    = 8'h00;
    localparam logic [7:0] RECOV_CTRL_RST   = 8'h01;
    localparam logic [7:0] VREF_CAL_DEFAULT = 8'h80;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_MHZ            = 200;
    localparam int RESET_TIMEOUT_US   = 64;
    localparam int RESET_TIMEOUT_CYC  = RESET_TIMEOUT_US * CLK_MHZ;

    typedef enum logic [1:0] {
        RSP_ST_OFF,
        RSP_ST_POR,
        RSP_ST_HOLD,
        RSP_ST_RUN
    } rsp_state_e;

endpackage : rsp_pkg

// ===== design/rsp_timeout.sv
// counter that holds internal reset for a fixed time after a start pulse
`timescale 1ns/100ps
module rsp_timeout
    import rsp_pkg::*;
#(
    parameter int CYCLES = RESET_TIMEOUT_CYC
) (
    input  wire logic clock,
    input  wire logic nrst,
    input  wire logic start,
    output logic      busy,
    output logic      done
);
    localparam int CW = $clog2(CYCLES + 1);

    logic [CW-1:0] count_reg;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            count_reg <= '0;
            busy      <= 1'b0;
            done      <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                count_reg <= CW'(CYCLES - 1);
                busy      <= 1'b1;
            end else if (busy) begin
                if (count_reg == '0) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    count_reg <= count_reg - 1'b1;
                end
            end
        end
    end

endmodule : rsp_timeout

// ===== design/rsp_irq.sv
// sticky event status with enable and write-one clear, one level interrupt
`timescale 1ns/100ps
module rsp_irq #(
    parameter int N = 3
) (
    input  wire logic         clock,
    input  wire logic         nrst,
    input  wire logic [N-1:0] events,
    input  wire logic [N-1:0] clear,
    input  wire logic         en_we,
    input  wire logic [N-1:0] en_wdata,
    output logic      [N-1:0] status,
    output logic      [N-1:0] enable,
    output logic              irq
);
    always_ff @(posedge clock) begin
        if (!nrst) begin
            status <= '0;
        end else begin
            // a new event wins over a clear in the same cycle
            status <= (status & ~clear) | events;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            enable <= '0;
        end else if (en_we) begin
            enable <= en_wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((status & ~clear) | events) & (en_we ? en_wdata : enable));
        end
    end

endmodule : rsp_irq

// ===== design/rsp_core.sv
// reset source recording, power-up sequencing and watchdog interrupt flag
//
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/100ps

// Overview of operation
// - reset cause bits 7:5 read zero
// - debug reset sets bit 4; clear
// - watchdog reset sets bit 3; clear
// - brown-out reset sets bit 2; clear
// - external reset sets bit 1; clear
// - power-on sets bit 0; software-only clear
// - above threshold: regulator on, reset, FETs off
// - hold internal reset for timeout after POR
// - in reset: calibration default, FETs off
// - after reset start deep recovery mode
// - recovery regulates only when cell below threshold
// - software may disable recovery when active
// - watchdog timeout in irq mode sets flag
// - flag cleared by vector or write one
// - irq needs flag, enable and global enable
module rsp_core
    import rsp_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = RESET_TIMEOUT_CYC
) (
    input  wire logic       clock,
    input  wire logic       nrst,
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    input  wire logic       battery_sense_pin_above_poweron_threshold,
    input  wire logic       cell_below_recovery_threshold,
    input  wire logic       debug_reset,
    input  wire logic       watchdog_reset,
    input  wire logic       brownout_reset,
    input  wire logic       external_reset,
    input  wire logic       watchdog_timeout,
    input  wire logic       watchdog_irq_mode,
    input  wire logic       watchdog_vector_ack,
    input  wire logic       global_irq_enable,
    output logic            regulator_on,
    output logic            poweron_reset,
    output logic            internal_reset,
    output logic            charge_fet_on,
    output logic            discharge_fet_on,
    output logic            recov_regulate,
    output logic      [7:0] vref_cal,
    output logic            watchdog_irq_req,
    output logic            irq
);

    // ************************************************************
    // decode
    // ************************************************************
    function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
        return a == r;
    endfunction : hit

    logic        wr_cause;
    logic        wr_wdog;
    logic        wr_recov;
    logic        wr_ien;
    logic        wr_iclr;
    assign wr_cause = wr && hit(addr, ADDR_RESET_CAUSE);
    assign wr_wdog  = wr && hit(addr, ADDR_WDOG_CTRL);
    assign wr_recov = wr && hit(addr, ADDR_RECOV_CTRL);
    assign wr_ien   = wr && hit(addr, ADDR_IRQ_ENABLE);
    assign wr_iclr  = wr && hit(addr, ADDR_IRQ_CLEAR);

    // ************************************************************
    // power-up sequence
    // ************************************************************
    rsp_state_e state_reg;
    logic       tmo_start;
    logic       tmo_busy;
    logic       tmo_done;
    logic       ready_pulse;

    assign tmo_start = (state_reg == RSP_ST_POR) && battery_sense_pin_above_poweron_threshold;

    rsp_timeout #(
        .CYCLES (TIMEOUT_CYCLES)
    ) u_timeout (
        .clock (clock),
        .nrst  (nrst),
        .start (tmo_start),
        .busy  (tmo_busy),
        .done  (tmo_done)
    );

    always_ff @(posedge clock) begin
        if (!nrst) begin
            state_reg <= RSP_ST_OFF;
        end else begin
            case (state_reg)
                RSP_ST_OFF: begin
                    if (battery_sense_pin_above_poweron_threshold) begin
                        state_reg <= RSP_ST_POR;
                    end
                end
                RSP_ST_POR: begin
                    if (!battery_sense_pin_above_poweron_threshold) begin
                        state_reg <= RSP_ST_OFF;
                    end else begin
                        state_reg <= RSP_ST_HOLD;
                    end
                end
                RSP_ST_HOLD: begin
                    if (!battery_sense_pin_above_poweron_threshold) begin
                        state_reg <= RSP_ST_OFF;
                    end else if (tmo_done) begin
                        state_reg <= RSP_ST_RUN;
                    end
                end
                RSP_ST_RUN: begin
                    if (!battery_sense_pin_above_poweron_threshold) begin
                        state_reg <= RSP_ST_OFF;
                    end
                end
                default: state_reg <= RSP_ST_OFF;
            endcase
        end
    end

    assign ready_pulse = (state_reg == RSP_ST_HOLD) && tmo_done
                         && battery_sense_pin_above_poweron_threshold;

    logic in_reset;
    assign in_reset = (state_reg != RSP_ST_RUN);

    always_ff @(posedge clock) begin
        if (!nrst) begin
            regulator_on   <= 1'b0;
            poweron_reset  <= 1'b0;
            internal_reset <= 1'b1;
        end else begin
            regulator_on   <= (state_reg != RSP_ST_OFF);
            poweron_reset  <= (state_reg == RSP_ST_POR);
            internal_reset <= in_reset && !ready_pulse;
        end
    end

    // ************************************************************
    // deep under-voltage recovery and FET drive
    // ************************************************************
    logic recov_enable_reg;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            recov_enable_reg <= RECOV_CTRL_RST[BIT_RECOV_EN];
        end else if (in_reset) begin
            recov_enable_reg <= 1'b1;
        end else if (wr_recov) begin
            recov_enable_reg <= wdata[BIT_RECOV_EN];
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            recov_regulate   <= 1'b0;
            charge_fet_on    <= 1'b0;
            discharge_fet_on <= 1'b0;
            vref_cal         <= VREF_CAL_DEFAULT;
        end else if (in_reset) begin
            recov_regulate   <= 1'b0;
            charge_fet_on    <= 1'b0;
            discharge_fet_on <= 1'b0;
            vref_cal         <= VREF_CAL_DEFAULT;
        end else begin
            recov_regulate   <= recov_enable_reg && cell_below_recovery_threshold;
            charge_fet_on    <= recov_enable_reg && cell_below_recovery_threshold;
            discharge_fet_on <= 1'b0;
        end
    end

    // ************************************************************
    // reset cause flags
    // ************************************************************
    logic [4:0] cause_reg;
    logic [4:0] cause_set;
    logic [4:0] cause_clr;
    logic       por_event;

    assign por_event = tmo_start;
    assign cause_set[BIT_POR_FLAG] = por_event;
    assign cause_set[BIT_EXT_FLAG] = external_reset;
    assign cause_set[BIT_BOD_FLAG] = brownout_reset;
    assign cause_set[BIT_WDR_FLAG] = watchdog_reset;
    assign cause_set[BIT_DBG_FLAG] = debug_reset;
    // only zeros written clear; ones are ignored
    assign cause_clr = wr_cause ? ~wdata[4:0] : 5'h00;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            cause_reg <= 5'h00;
        end else if (por_event) begin
            cause_reg <= 5'h01;
        end else begin
            cause_reg <= (cause_reg & ~cause_clr) | cause_set;
        end
    end

    // ************************************************************
    // watchdog interrupt flag
    // ************************************************************
    logic wdog_flag_reg;
    logic wdog_ie_reg;
    logic wdog_flag_set;
    logic wdog_flag_clr;

    assign wdog_flag_set = watchdog_timeout && watchdog_irq_mode;
    assign wdog_flag_clr = watchdog_vector_ack || (wr_wdog && wdata[BIT_WDOG_FLAG]);

    always_ff @(posedge clock) begin
        if (!nrst) begin
            wdog_flag_reg <= WDOG_CTRL_RST[BIT_WDOG_FLAG];
            wdog_ie_reg   <= WDOG_CTRL_RST[BIT_WDOG_IE];
        end else begin
            wdog_flag_reg <= wdog_flag_set | (wdog_flag_reg & ~wdog_flag_clr);
            if (wr_wdog) begin
                wdog_ie_reg <= wdata[BIT_WDOG_IE];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            watchdog_irq_req <= 1'b0;
        end else begin
            watchdog_irq_req <= wdog_flag_reg && wdog_ie_reg && global_irq_enable;
        end
    end

    // ************************************************************
    // block interrupt
    // ************************************************************
    logic [2:0] irq_events;
    logic [2:0] irq_status;
    logic [2:0] irq_enable;

    assign irq_events[IRQ_BIT_RESET] = |cause_set[4:1];
    assign irq_events[IRQ_BIT_WDOG]  = wdog_flag_set;
    assign irq_events[IRQ_BIT_READY] = ready_pulse;

    rsp_irq #(
        .N (3)
    ) u_irq (
        .clock    (clock),
        .nrst     (nrst),
        .events   (irq_events),
        .clear    (wr_iclr ? wdata[2:0] : 3'h0),
        .en_we    (wr_ien),
        .en_wdata (wdata[2:0]),
        .status   (irq_status),
        .enable   (irq_enable),
        .irq      (irq)
    );

    // ************************************************************
    // read port
    // ************************************************************
    always_ff @(posedge clock) begin
        if (!nrst) begin
            rdata <= 8'h00;
        end else if (rd) begin
            case (addr)
                ADDR_RESET_CAUSE: rdata <= {3'h0, cause_reg};
                ADDR_WDOG_CTRL:   rdata <= {wdog_flag_reg, wdog_ie_reg, 6'h00};
                ADDR_RECOV_CTRL:  rdata <= {7'h00, recov_enable_reg};
                ADDR_IRQ_STATUS:  rdata <= {5'h00, irq_status};
                ADDR_IRQ_ENABLE:  rdata <= {5'h00, irq_enable};
                ADDR_PWR_STATUS:  rdata <= {4'h0, recov_regulate, tmo_busy,
                                            internal_reset, regulator_on};
                default:          rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

endmodule : rsp_core

// ===== bench/rsp_core_props.sv
// concurrent checks on the ports of the reset and power-up core
`timescale 1ns/100ps
module rsp_core_props
    import rsp_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = RESET_TIMEOUT_CYC
) (
    input wire logic       clock,
    input wire logic       nrst,
    input wire logic [3:0] addr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    input wire logic       cell_below_recovery_threshold,
    input wire logic       watchdog_timeout,
    input wire logic       watchdog_irq_mode,
    input wire logic       global_irq_enable,
    input wire logic       regulator_on,
    input wire logic       poweron_reset,
    input wire logic       internal_reset,
    input wire logic       charge_fet_on,
    input wire logic       discharge_fet_on,
    input wire logic       recov_regulate,
    input wire logic [7:0] vref_cal,
    input wire logic       watchdog_irq_req
);
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    // cycles since the power-on pulse ended
    int hold_cnt;
    always_ff @(posedge clock) begin
        if (!nrst || poweron_reset)
            hold_cnt <= 0;
        else
            hold_cnt <= hold_cnt + 1;
    end

    property p_rsvd;
        rd && addr == ADDR_RESET_CAUSE |=> rdata[7:5] == 3'h0;
    endproperty
    property p_por_reg;
        poweron_reset |-> regulator_on && internal_reset;
    endproperty
    property p_hold;
        $fell(internal_reset) |->
            hold_cnt >= TIMEOUT_CYCLES && hold_cnt <= TIMEOUT_CYCLES + 4;
    endproperty
    property p_fet_off;
        internal_reset && $past(internal_reset) |-> !charge_fet_on && !discharge_fet_on;
    endproperty
    property p_cal_dflt;
        internal_reset && $past(internal_reset) |-> vref_cal == VREF_CAL_DEFAULT;
    endproperty
    property p_release;
        $fell(internal_reset) && cell_below_recovery_threshold |-> ##[0:2] recov_regulate;
    endproperty
    property p_recov_cell;
        !cell_below_recovery_threshold [*3] |-> !recov_regulate;
    endproperty
    property p_wdog_flag_set;
        watchdog_timeout && watchdog_irq_mode ##1 rd && addr == ADDR_WDOG_CTRL
            |=> rdata[BIT_WDOG_FLAG];
    endproperty
    property p_req;
        watchdog_irq_req |-> $past(global_irq_enable);
    endproperty

    a_rsvd: assert property (p_rsvd) else $error("reserved cause bits not zero");
    a_por_reg: assert property (p_por_reg) else $error("power-on pulse without supply");
    a_hold: assert property (p_hold) else $error("internal reset hold time wrong");
    a_fet_off: assert property (p_fet_off) else $error("fet driven in reset");
    a_cal_dflt: assert property (p_cal_dflt) else $error("calibration not default");
    a_release: assert property (p_release) else $error("recovery mode not started");
    a_recov_cell: assert property (p_recov_cell) else $error("recovery regulates high cell");
    a_wdog_flag_set: assert property (p_wdog_flag_set) else $error("watchdog flag not set");
    a_req: assert property (p_req) else $error("watchdog request with global off");

    c_por: cover property (poweron_reset);
    c_release: cover property ($fell(internal_reset));
    c_req: cover property (watchdog_irq_req);
endmodule : rsp_core_props

// ===== bench/rsp_battery_sense_pin_model.sv
// battery, charger and sense model driving the block's threshold inputs
`timescale 1ns/100ps
module rsp_battery_sense_pin_model (
    input  wire logic clock,
    input  wire logic charger_on,
    input  wire logic cell_low,
    output logic      battery_sense_pin_above_poweron_threshold,
    output logic      cell_below_recovery_threshold
);
    // ****************************************
    // supply ramp
    // ****************************************
    logic [1:0] ramp_reg = 2'h0;
    // supply climbs past the threshold a few cycles after the charger, drops at once
    always_ff @(posedge clock) begin
        ramp_reg <= charger_on ? {ramp_reg[0], 1'b1} : 2'h0;
    end
    assign battery_sense_pin_above_poweron_threshold  = ramp_reg[1];
    assign cell_below_recovery_threshold = cell_low;
endmodule : rsp_battery_sense_pin_model

// ===== bench/tb_reset_source_and_powerup_control.sv
// self-checking bench for the reset source and power-up core
`timescale 1ns/100ps
module tb_reset_source_and_powerup_control;
    import rsp_pkg::*;
    // ****************************************
    // bench signals and tasks
    // ****************************************
    logic       clock = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0;
    logic       charger_on = 1'b0, cell_low = 1'b1, wd_mode = 1'b1, gie = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [5:0] src = 6'h00;
    logic [7:0] wdata = 8'h00, exp_cause;
    wire logic  battery_sense_pin_ok, cell_bl, reg_on, por, irst, chg, dchg, recov, wreq, irq;
    wire logic [7:0] rdata, vcal;
    int         miscompares = 0, samples_checked = 0;

    rsp_battery_sense_pin_model rsp_battery_sense_pin_model_inst (.clock(clock), .charger_on(charger_on),
        .cell_low(cell_low), .battery_sense_pin_above_poweron_threshold(battery_sense_pin_ok),
        .cell_below_recovery_threshold(cell_bl));

    rsp_core #(.TIMEOUT_CYCLES(8)) rsp_core_inst (.clock(clock), .nrst(nrst),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .battery_sense_pin_above_poweron_threshold(battery_sense_pin_ok), .cell_below_recovery_threshold(cell_bl),
        .debug_reset(src[3]), .watchdog_reset(src[2]), .brownout_reset(src[1]),
        .external_reset(src[0]), .watchdog_timeout(src[4]), .watchdog_irq_mode(wd_mode),
        .watchdog_vector_ack(src[5]), .global_irq_enable(gie), .regulator_on(reg_on),
        .poweron_reset(por), .internal_reset(irst), .charge_fet_on(chg),
        .discharge_fet_on(dchg), .recov_regulate(recov), .vref_cal(vcal),
        .watchdog_irq_req(wreq), .irq(irq));

    initial begin
        forever #2.5 clock = ~clock;
    end

    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] ev);
        samples_checked++;
        if (seen !== ev) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, ev, seen);
        end
    endtask : check

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
        @(posedge clock);
    endtask : wr_reg

    task automatic rd_reg(input logic [3:0] a, input logic [7:0] ev);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        check($sformatf("register %h", a), rdata, ev);
        @(posedge clock);
    endtask : rd_reg

    task automatic pulse(input int i);
        src[i] <= 1'b1;
        @(posedge clock);
        src[i] <= 1'b0;
        @(posedge clock);
    endtask : pulse

    task automatic power_up();
        charger_on <= 1'b1;
        for (int n = 0; n < 40 && irst !== 1'b0; n++) @(posedge clock);
        check("internal_reset", irst, 1'b0);
        check("regulator_on", reg_on, 1'b1);
    endtask : power_up

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report

    initial begin
        repeat (3000) @(posedge clock);
        miscompares++;
        final_report();
    end

    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        repeat (12) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        rd_reg(ADDR_RESET_CAUSE, 8'h00);
        check("regulator_on", reg_on, 1'b0);
        check("vref_cal", vcal, 8'h80);
        check("charge_fet_on", chg, 1'b0);
        check("discharge_fet_on", dchg, 1'b0);
        power_up();
        rd_reg(ADDR_RESET_CAUSE, 8'h01);
        check("recov_regulate", recov, 1'b1);
        check("charge_fet_on", chg, 1'b1);
        cell_low <= 1'b0;
        repeat (3) @(posedge clock);
        check("recov_regulate", recov, 1'b0);
        cell_low <= 1'b1;
        wr_reg(ADDR_RECOV_CTRL, 8'h00);
        repeat (2) @(posedge clock);
        check("recov_regulate", recov, 1'b0);
        exp_cause = 8'h01;
        for (int i = 0; i < 4; i++) begin
            pulse(i);
            exp_cause[i+1] = 1'b1;
            rd_reg(ADDR_RESET_CAUSE, exp_cause);
        end
        wr_reg(ADDR_RESET_CAUSE, 8'hFF);
        rd_reg(ADDR_RESET_CAUSE, 8'h1F);
        for (int i = 4; i > 0; i--) begin
            exp_cause[i] = 1'b0;
            wr_reg(ADDR_RESET_CAUSE, exp_cause);
            rd_reg(ADDR_RESET_CAUSE, exp_cause);
        end
        wr_reg(ADDR_RESET_CAUSE, 8'h00);
        rd_reg(ADDR_RESET_CAUSE, 8'h00);
        pulse(1);
        charger_on <= 1'b0;
        repeat (4) @(posedge clock);
        power_up();
        rd_reg(ADDR_RESET_CAUSE, 8'h01);
        wr_reg(ADDR_WDOG_CTRL, 8'h40);
        gie <= 1'b1;
        src[4] <= 1'b1;
        @(posedge clock);
        src[4] <= 1'b0;
        rd_reg(ADDR_WDOG_CTRL, 8'hC0);
        check("watchdog_irq_req", wreq, 1'b1);
        gie <= 1'b0;
        repeat (2) @(posedge clock);
        check("watchdog_irq_req", wreq, 1'b0);
        wr_reg(ADDR_WDOG_CTRL, 8'hC0);
        rd_reg(ADDR_WDOG_CTRL, 8'h40);
        pulse(4);
        pulse(5);
        rd_reg(ADDR_WDOG_CTRL, 8'h40);
        wd_mode <= 1'b0;
        pulse(4);
        rd_reg(ADDR_WDOG_CTRL, 8'h40);
        wd_mode <= 1'b1;
        wr_reg(ADDR_IRQ_CLEAR, 8'h07);
        rd_reg(ADDR_IRQ_STATUS, 8'h00);
        wr_reg(ADDR_IRQ_ENABLE, 8'h02);
        pulse(0);
        rd_reg(ADDR_IRQ_STATUS, 8'h01);
        check("irq", irq, 1'b0);
        pulse(4);
        rd_reg(ADDR_IRQ_STATUS, 8'h03);
        check("irq", irq, 1'b1);
        wr_reg(ADDR_IRQ_CLEAR, 8'h02);
        @(posedge clock);
        check("irq", irq, 1'b0);
        wr_reg(4'hF, 8'hFF);
        rd_reg(4'hF, 8'h00);
        rd_reg(ADDR_IRQ_ENABLE, 8'h02);
        rd_reg(ADDR_IRQ_CLEAR, 8'h00);
        final_report();
    end
endmodule : tb_reset_source_and_powerup_control

bind rsp_core rsp_core_props #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) rsp_core_props_inst (
    .clock(clock), .nrst(nrst), .addr(addr), .rd(rd), .rdata(rdata),
    .cell_below_recovery_threshold(cell_below_recovery_threshold),
    .watchdog_timeout(watchdog_timeout), .watchdog_irq_mode(watchdog_irq_mode),
    .global_irq_enable(global_irq_enable), .regulator_on(regulator_on),
    .poweron_reset(poweron_reset), .internal_reset(internal_reset),
    .charge_fet_on(charge_fet_on), .discharge_fet_on(discharge_fet_on),
    .recov_regulate(recov_regulate), .vref_cal(vref_cal),
    .watchdog_irq_req(watchdog_irq_req));
